//--- logic/cmp_multiphase_pwm.sv
// per-rail compensators, phase distribution and sync for the multiphase modulator
//
// Functional notes
// (RQ1) per rail: nonlinear gain, biquad, first-order section
// (RQ2) three coefficient banks: ramp, regulation, light load
// (RQ3) gain picked by error versus four limits
// (RQ4) limits independent, asymmetric allowed, -32 to 31
// (RQ5) all limits positive: gain zero for negatives
// (RQ6) first-order section gives third zero, pole
// (RQ7) duty output clamped from zero to full
// (RQ8) threshold equals duty times period
// (RQ9) counter compare sets gate pulse width
// (RQ10) rails follow sync input; one drives sync out
// (RQ11) up to four rails, stages each programmable
// (RQ12) stage-to-rail map sets rails and stage counts
// (RQ13) sample trigger from rail's first modulator timer
// (RQ14) unused sense front ends are disabled
// (RQ15) rail first stages spread by 3/13 fastest
// (RQ16) stage edges spaced period over stage count
// (RQ17) error saturates at -32 and +31
// (RQ18) sync rise resets following rail's timer
// (RQ19) one duty per period, applied at boundary
`timescale 1ns/1ps
module cmp_multiphase_pwm
  import cmp_pkg::*;
#(
  parameter int NSTAGE = CMP_NSTAGE,
  parameter int ERRCW = CMP_ERRCW
)
(
  input wire logic mclk, // device clock, 10 MHz
  input wire logic arst_n, // async reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire logic enable, // run the rails
  input wire logic restart, // pulse: realign rail spacing
  input wire logic [CMP_NRAIL-1:0][CMP_PERW-1:0] period, // switching period per rail
  input wire logic [CMP_NRAIL-1:0][CMP_PERW-1:0] sampleAt, // sample trigger point per rail
  input wire logic [NSTAGE-1:0][CMP_RAILW-1:0] stageRail, // rail of each stage
  input wire logic [NSTAGE-1:0] stageOn, // stage configured
  input wire logic [CMP_NRAIL-1:0] railRamp, // rail is ramping or tracking
  input wire logic [CMP_NRAIL-1:0] railLight, // rail below light-load threshold
  input wire cmp_coef_type [CMP_NRAIL-1:0][CMP_NBANK-1:0] coef, // coefficient banks
  input wire logic [CMP_NRAIL-1:0][ERRCW-1:0] errIn, // raw error converter words
  input wire logic [CMP_NRAIL-1:0] errDone, // error word valid pulse
  input wire logic [CMP_NRAIL-1:0] syncInMask, // rails following sync input
  input wire logic [7:0] syncOutSel, // rail driving sync output
  input wire logic syncIn, // external sync input
  output logic [NSTAGE-1:0] gate, // gate drive pulses
  output logic [CMP_NRAIL-1:0] convTrig, // error converter sample pulses
  output logic [CMP_NRAIL-1:0] senseEn, // sense front end enables
  output logic syncOut, // sync output
  output logic [CMP_NRAIL-1:0][CMP_DUTYW:0] dutyOut, // applied duty per rail
  output logic [CMP_NRAIL-1:0][1:0] bankOut // last bank used per rail
);

  if (NSTAGE < 1 || NSTAGE > (1 << CMP_STGW) || NSTAGE < CMP_NRAIL)
    $error("cmp_multiphase_pwm: NSTAGE out of range");
  if (ERRCW < CMP_ERRW || ERRCW > CMP_ACCW)
    $error("cmp_multiphase_pwm: ERRCW out of range");

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic helpers

  function automatic logic signed [CMP_ACCW-1:0] sat_acc(input logic signed [CMP_MACW-1:0] a);
    logic signed [CMP_MACW-1:0] hi;
    logic signed [CMP_MACW-1:0] lo;
    hi = CMP_MACW'({1'b0, {(CMP_ACCW-1){1'b1}}});
    lo = -hi - CMP_MACW'(1);
    if (a > hi)
      sat_acc = hi[CMP_ACCW-1:0];
    else if (a < lo)
      sat_acc = lo[CMP_ACCW-1:0];
    else
      sat_acc = a[CMP_ACCW-1:0];
  endfunction : sat_acc

  function automatic logic signed [CMP_ERRW-1:0] sat_err(input logic signed [ERRCW-1:0] a);
    // (RQ17) clip to the -32..31 error range
    if (a > ERRCW'(CMP_ERR_MAX))
      sat_err = CMP_ERR_MAX;
    else if (a < ERRCW'(CMP_ERR_MIN))
      sat_err = CMP_ERR_MIN;
    else
      sat_err = a[CMP_ERRW-1:0];
  endfunction : sat_err

  ////////////////////////////////////////////////////////////////////////////
  // phase configuration decode

  logic [CMP_NRAIL-1:0][CMP_STGW:0] railN;
  logic [CMP_NRAIL-1:0][CMP_STGW-1:0] firstStg;
  logic [NSTAGE-1:0][CMP_STGW-1:0] stageOrd;
  logic [CMP_NRAIL-1:0] railUsed;
  logic [NSTAGE-1:0][CMP_PERW-1:0] stageOffs;
  logic [CMP_PERW-1:0] fastest;
  logic [CMP_PERW-1:0] spread;

  // (RQ12) stage map gives rails and counts
  always_comb
  begin
    railN = '0;
    firstStg = '0;
    stageOrd = '0;
    stageOffs = '0;
    fastest = '1;
    for (int s = NSTAGE - 1; s >= 0; s--)
      if (stageOn[s])
        firstStg[stageRail[s]] = CMP_STGW'(s);
    for (int s = 0; s < NSTAGE; s++)
      if (stageOn[s])
      begin
        stageOrd[s] = railN[stageRail[s]][CMP_STGW-1:0];
        railN[stageRail[s]] = railN[stageRail[s]] + 1'b1;
      end
    for (int r = 0; r < CMP_NRAIL; r++)
    begin
      railUsed[r] = (railN[r] != '0);
      if (railUsed[r] && period[r] < fastest)
        fastest = period[r];
    end
    // (RQ16) stage k starts k*period/N into the rail period
    for (int s = 0; s < NSTAGE; s++)
      if (stageOn[s])
        stageOffs[s] = CMP_PERW'(({3'b000, stageOrd[s]} * {3'b000, period[stageRail[s]]}) /
                                 railN[stageRail[s]]);
  end

  // (RQ15) spacing is 3/13 of fastest rail period
  assign spread = CMP_PERW'(({4'h0, fastest} * CMP_SPREAD_NUM) / CMP_SPREAD_DEN);

  ////////////////////////////////////////////////////////////////////////////
  // state

  cmp_state_type st_r;
  cmp_state_type st_nxt;

  always_comb
  begin
    logic syncRise;
    logic doAlign;
    logic wrap;
    logic [CMP_STGW-1:0] fs;
    logic [1:0] bank;
    logic [2:0] seg;
    logic [CMP_STGW-1:0] ordinal;
    logic [CMP_PERW+CMP_STGW-1:0] delay;
    logic signed [CMP_ERRW-1:0] e;
    logic signed [CMP_MACW-1:0] macc;
    logic signed [CMP_ACCW-1:0] u;
    logic signed [CMP_ACCW-1:0] v;
    logic signed [CMP_ACCW-1:0] y;
    cmp_coef_type cf;
    syncRise = 1'b0;
    doAlign = 1'b0;
    wrap = 1'b0;
    fs = '0;
    bank = CMP_BANK_REG;
    seg = '0;
    ordinal = '0;
    delay = '0;
    e = '0;
    macc = '0;
    u = '0;
    v = '0;
    y = '0;
    cf = '0;
    st_nxt = st_r;
    st_nxt.syncPrev = syncIn;
    syncRise = syncIn && !st_r.syncPrev;
    st_nxt.convTrig = '0;
    st_nxt.senseEn = '0;

    case (st_r.mode)
      CMP_IDLE:
        if (enable)
        begin
          st_nxt.mode = CMP_RUN;
          doAlign = 1'b1;
        end
      CMP_RUN:
        if (!enable)
          st_nxt.mode = CMP_IDLE;
        else if (restart)
          doAlign = 1'b1;
      default:
        st_nxt.mode = CMP_IDLE;
    endcase

    for (int r = 0; r < CMP_NRAIL; r++)
    begin
      fs = firstStg[r];
      // (RQ14) only sense inputs feeding a rail run
      if (railUsed[r] && fs < CMP_STGW'(CMP_NRAIL) && enable)
        st_nxt.senseEn[fs[CMP_RAILW-1:0]] = 1'b1;

      if (st_r.mode != CMP_RUN)
      begin
        // outputs off; filter history dropped so the next enable begins clean
        st_nxt.rail[r] = '0;
        st_nxt.rail[r].bank = CMP_BANK_RAMP;
      end
      else
      begin
        wrap = (st_r.rail[r].cnt >= period[r] - 1'b1);
        // (RQ18) sync rise resets following rail
        if (syncRise && syncInMask[r])
          st_nxt.rail[r].cnt = '0;
        else if (wrap)
          st_nxt.rail[r].cnt = '0;
        else
          st_nxt.rail[r].cnt = st_r.rail[r].cnt + 1'b1;

        // (RQ19) new duty applied at period boundary
        if (wrap)
        begin
          st_nxt.rail[r].dutyAct = st_r.rail[r].dutyPend;
          // (RQ8) threshold equals duty times period
          st_nxt.rail[r].thr = (CMP_PERW+1)'(({{CMP_PERW{1'b0}}, st_r.rail[r].dutyPend} *
                                {{(CMP_DUTYW+1){1'b0}}, period[r]}) >> CMP_DUTYW);
        end

        // (RQ13) trigger from first modulator's timer
        if (railUsed[r] && fs < CMP_STGW'(CMP_NRAIL) && st_r.rail[r].cnt == sampleAt[r])
          st_nxt.convTrig[fs[CMP_RAILW-1:0]] = 1'b1;

        if (railUsed[r] && fs < CMP_STGW'(CMP_NRAIL) && errDone[fs[CMP_RAILW-1:0]])
        begin
          // (RQ2) bank follows ramp or light load
          if (railRamp[r])
            bank = CMP_BANK_RAMP;
          else if (railLight[r])
            bank = CMP_BANK_LIGHT;
          else
            bank = CMP_BANK_REG;
          cf = coef[r][bank];
          e = sat_err($signed(errIn[fs[CMP_RAILW-1:0]]));
          // (RQ3) segment index counts limits below error
          seg = '0;
          for (int l = 0; l < CMP_NLIMIT; l++)
            // (RQ4) each limit compared on its own
            if (e > $signed(cf.limit[l]))
              seg = seg + 1'b1;
          // (RQ5) errors under every limit take gain zero
          // widen both factors first: a self-sized product would wrap at gain width
          u = $signed({{(CMP_ACCW-CMP_ERRW){e[CMP_ERRW-1]}}, e}) *
              $signed({{(CMP_ACCW-CMP_GAINW){cf.gain[seg][CMP_GAINW-1]}}, cf.gain[seg]});
          // (RQ1) biquad after nonlinear gain
          macc = $signed(cf.bq[0]) * u + $signed(cf.bq[1]) * $signed(st_r.rail[r].u1) +
                 $signed(cf.bq[2]) * $signed(st_r.rail[r].u2) -
                 $signed(cf.bq[3]) * $signed(st_r.rail[r].v1) -
                 $signed(cf.bq[4]) * $signed(st_r.rail[r].v2);
          v = sat_acc(macc >>> CMP_COEF_FRAC);
          // (RQ6) first-order section adds third zero and pole
          macc = $signed(cf.fo[0]) * v + $signed(cf.fo[1]) * $signed(st_r.rail[r].v1) -
                 $signed(cf.fo[2]) * $signed(st_r.rail[r].y1);
          y = sat_acc(macc >>> CMP_COEF_FRAC);
          st_nxt.rail[r].u2 = st_r.rail[r].u1;
          st_nxt.rail[r].u1 = u;
          st_nxt.rail[r].v2 = st_r.rail[r].v1;
          st_nxt.rail[r].v1 = v;
          st_nxt.rail[r].y1 = y;
          st_nxt.rail[r].bank = bank;
          // (RQ7) duty clamped to zero..full
          if (y < 0)
            st_nxt.rail[r].dutyPend = CMP_DUTY_ZERO;
          else if (y > CMP_ACCW'(CMP_DUTY_FULL))
            st_nxt.rail[r].dutyPend = CMP_DUTY_FULL;
          else
            st_nxt.rail[r].dutyPend = y[CMP_DUTYW:0];
        end
      end

      // (RQ15) used rails start staggered by spread
      if (doAlign && railUsed[r])
      begin
        delay = (CMP_PERW+CMP_STGW)'(({{CMP_PERW{1'b0}}, ordinal} * {{CMP_STGW{1'b0}}, spread}) %
                                    {{CMP_STGW{1'b0}}, period[r]});
        if (delay == '0)
          st_nxt.rail[r].cnt = '0;
        else
          st_nxt.rail[r].cnt = period[r] - delay[CMP_PERW-1:0];
        ordinal = ordinal + 1'b1;
      end
    end

    // (RQ10) selected rail drives sync out, first half period
    st_nxt.syncOut = 1'b0;
    for (int r = 0; r < CMP_NRAIL; r++)
      if (syncOutSel == 8'(r) && st_nxt.mode == CMP_RUN)
        st_nxt.syncOut = (st_nxt.rail[r].cnt < (period[r] >> 1));
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r <= '0;
      st_r.mode <= CMP_IDLE;
    end
    else if (ce)
      st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // stage modulators

  // (RQ11) each stage follows its own rail
  for (genvar s = 0; s < NSTAGE; s++)
  begin : g_stage
    cmp_stage_mod u_stage (
      .mclk(mclk),
      .arst_n(arst_n),
      .ce(ce),
      .en(stageOn[s] && st_r.mode == CMP_RUN),
      .cnt(st_r.rail[stageRail[s]].cnt),
      .period(period[stageRail[s]]),
      .offset(stageOffs[s]),
      .thr(st_r.rail[stageRail[s]].thr),
      .gate(gate[s])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign convTrig = st_r.convTrig;
  assign senseEn = st_r.senseEn;
  assign syncOut = st_r.syncOut;

  for (genvar r = 0; r < CMP_NRAIL; r++)
  begin : g_out
    assign dutyOut[r] = st_r.rail[r].dutyAct;
    assign bankOut[r] = st_r.rail[r].bank;
  end

endmodule : cmp_multiphase_pwm

//--- logic/cmp_pkg.sv
// constants and carrier types for the compensated multiphase pulse modulator
package cmp_pkg;

  localparam int CMP_NRAIL = 4;
  localparam int CMP_NSTAGE = 6;
  localparam int CMP_NBANK = 3;
  localparam int CMP_NLIMIT = 4;
  localparam int CMP_NGAIN = CMP_NLIMIT + 1;
  localparam int CMP_ERRCW = 10;
  localparam int CMP_ERRW = 6;
  localparam int CMP_GAINW = 8;
  localparam int CMP_COEFW = 16;
  localparam int CMP_COEF_FRAC = 14;
  localparam int CMP_ACCW = 24;
  localparam int CMP_MACW = CMP_ACCW + CMP_COEFW + 3;
  localparam int CMP_DUTYW = 12;
  localparam int CMP_PERW = 16;
  localparam int CMP_RAILW = 2;
  localparam int CMP_STGW = 3;

  localparam logic signed [CMP_ERRW-1:0] CMP_ERR_MIN = -6'sd32;
  localparam logic signed [CMP_ERRW-1:0] CMP_ERR_MAX = 6'sd31;
  localparam logic [CMP_DUTYW:0] CMP_DUTY_FULL = 13'h1000;
  localparam logic [CMP_DUTYW:0] CMP_DUTY_ZERO = 13'h0000;
  localparam logic [3:0] CMP_SPREAD_NUM = 4'h3;
  localparam logic [3:0] CMP_SPREAD_DEN = 4'hd;
  localparam logic [1:0] CMP_BANK_RAMP = 2'h0;
  localparam logic [1:0] CMP_BANK_REG = 2'h1;
  localparam logic [1:0] CMP_BANK_LIGHT = 2'h2;

  // bq: b0 b1 b2 a1 a2 ; fo: b3 b4 a3 ; all signed fixed point
  typedef struct packed {
    logic [CMP_NLIMIT-1:0][CMP_ERRW-1:0] limit;
    logic [CMP_NGAIN-1:0][CMP_GAINW-1:0] gain;
    logic [4:0][CMP_COEFW-1:0] bq;
    logic [2:0][CMP_COEFW-1:0] fo;
  } cmp_coef_type;

  typedef enum logic [0:0] {CMP_IDLE, CMP_RUN} cmp_mode_type;

  typedef struct packed {
    logic [CMP_ACCW-1:0] u1;
    logic [CMP_ACCW-1:0] u2;
    logic [CMP_ACCW-1:0] v1;
    logic [CMP_ACCW-1:0] v2;
    logic [CMP_ACCW-1:0] y1;
    logic [CMP_DUTYW:0] dutyPend;
    logic [CMP_DUTYW:0] dutyAct;
    logic [CMP_PERW:0] thr;
    logic [CMP_PERW-1:0] cnt;
    logic [1:0] bank;
  } cmp_rail_type;

  typedef struct packed {
    cmp_mode_type mode;
    cmp_rail_type [CMP_NRAIL-1:0] rail;
    logic syncPrev;
    logic syncOut;
    logic [CMP_NRAIL-1:0] convTrig;
    logic [CMP_NRAIL-1:0] senseEn;
  } cmp_state_type;

endpackage : cmp_pkg

//--- logic/cmp_stage_mod.sv
// one power-stage counter-compare modulator with phase offset
`timescale 1ns/1ps
module cmp_stage_mod
  import cmp_pkg::*;
(
  input wire logic mclk, // device clock
  input wire logic arst_n, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic en, // stage in use and block running
  input wire logic [CMP_PERW-1:0] cnt, // rail period counter
  input wire logic [CMP_PERW-1:0] period, // rail period in clocks
  input wire logic [CMP_PERW-1:0] offset, // phase offset of this stage
  input wire logic [CMP_PERW:0] thr, // compare threshold
  output logic gate // gate drive pulse
);

  typedef struct packed {
    logic gate;
  } cmp_stg_state_type;

  cmp_stg_state_type st_r;
  cmp_stg_state_type st_nxt;
  logic [CMP_PERW:0] local_cnt;

  always_comb
  begin
    st_nxt = st_r;
    // shifted counter: rising edge lands where cnt equals offset
    if (cnt >= offset)
      local_cnt = {1'b0, cnt} - {1'b0, offset};
    else
      local_cnt = {1'b0, cnt} + {1'b0, period} - {1'b0, offset};
    // (RQ9) counter compare sets width
    st_nxt.gate = en && (local_cnt < thr);
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      st_r <= '0;
    else if (ce)
      st_r <= st_nxt;
  end

  assign gate = st_r.gate;

endmodule : cmp_stage_mod

//--- test/cmp_multiphase_pwm_chk.sv
// port assertions for the multiphase modulator
`timescale 1ns/1ps
module cmp_multiphase_pwm_chk
  import cmp_pkg::*;
#(
  parameter int NSTAGE = CMP_NSTAGE
)
(
  input wire logic mclk, // clock
  input wire logic arst_n, // reset
  input wire logic ce, // clock enable
  input wire logic enable, // run
  input wire logic restart, // realign
  input wire logic [NSTAGE-1:0][CMP_RAILW-1:0] stageRail, // stage map
  input wire logic [NSTAGE-1:0] stageOn, // stage used
  input wire logic [CMP_NRAIL-1:0] railRamp, // ramp bank
  input wire logic [CMP_NRAIL-1:0] errDone, // word valid
  input wire logic [CMP_NRAIL-1:0] syncInMask, // sync followers
  input wire logic [7:0] syncOutSel, // sync source
  input wire logic syncIn, // sync in
  input wire logic [NSTAGE-1:0] gate, // gates
  input wire logic [CMP_NRAIL-1:0] convTrig, // triggers
  input wire logic [CMP_NRAIL-1:0] senseEn, // sense on
  input wire logic syncOut, // sync out
  input wire logic [CMP_NRAIL-1:0][CMP_DUTYW:0] dutyOut, // duty
  input wire logic [CMP_NRAIL-1:0][1:0] bankOut // bank
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // past values only trusted once reset has been gone a cycle
  sequence s_run;
    ce && enable && $past(enable) && $past(arst_n);
  endsequence
  property p_duty_range;
    dutyOut[0] <= CMP_DUTY_FULL && dutyOut[3] <= CMP_DUTY_FULL;
  endproperty
  a_duty_range: assert property (p_duty_range) else $error("duty above full scale");
  property p_sense_off;
    ce && !enable |=> senseEn == '0;
  endproperty
  a_sense_off: assert property (p_sense_off) else $error("sense enabled while idle");
  property p_trig_pulse;
    ce && convTrig[0] |=> !convTrig[0];
  endproperty
  a_trig_pulse: assert property (p_trig_pulse) else $error("trigger longer than a cycle");
  property p_bank_ramp;
    s_run ##0 (errDone[0] && railRamp[0] && stageOn[0] && stageRail[0] == 2'h0) |=> bankOut[0] == CMP_BANK_RAMP;
  endproperty
  a_bank_ramp: assert property (p_bank_ramp) else $error("ramp bank not used");
  property p_sync_rst;
    s_run ##0 ($rose(syncIn) && syncInMask[0] && syncOutSel == 8'h00) |=> syncOut;
  endproperty
  a_sync_rst: assert property (p_sync_rst) else $error("sync edge did not restart rail");
  property p_sync_off;
    ce && syncOutSel > 8'h03 |=> !syncOut;
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("sync out not disabled");
  property p_idle;
    ce && !enable ##1 ce && !enable |=> gate == '0 && dutyOut == '0;
  endproperty
  a_idle: assert property (p_idle) else $error("pulses while idle");
  property p_duty_hold;
    s_run ##0 (!restart && $changed(dutyOut[0])) |=> $stable(dutyOut[0]);
  endproperty
  a_duty_hold: assert property (p_duty_hold) else $error("duty changed twice in a period");
endmodule : cmp_multiphase_pwm_chk
bind cmp_multiphase_pwm cmp_multiphase_pwm_chk #(.NSTAGE(NSTAGE)) u_chk
(
  .mclk(mclk), .arst_n(arst_n), .ce(ce), .enable(enable), .restart(restart), .stageRail(stageRail),
  .stageOn(stageOn), .railRamp(railRamp), .errDone(errDone), .syncInMask(syncInMask),
  .syncOutSel(syncOutSel), .syncIn(syncIn), .gate(gate), .convTrig(convTrig), .senseEn(senseEn),
  .syncOut(syncOut), .dutyOut(dutyOut), .bankOut(bankOut)
);

//--- test/cmp_sense_model.sv
// far side: converts the sensed error when a trigger arrives
`timescale 1ns/1ps
module cmp_sense_model
  import cmp_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic arst_n, // reset
  input wire logic [CMP_NRAIL-1:0] convTrig, // sample request
  input wire logic [CMP_NRAIL-1:0][CMP_ERRCW-1:0] errVal, // value to report
  output logic [CMP_NRAIL-1:0][CMP_ERRCW-1:0] errIn, // error word
  output logic [CMP_NRAIL-1:0] errDone // word valid
);
  logic [CMP_NRAIL-1:0][2:0] dly;
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dly <= '0;
      errDone <= '0;
      errIn <= '0;
    end
    else
      for (int i = 0; i < CMP_NRAIL; i++)
      begin
        dly[i] <= {dly[i][1:0], convTrig[i]};
        errDone[i] <= dly[i][2];
        // answer on same index
        // outside valid the word toggles so stale data never looks good
        errIn[i] <= dly[i][2] ? errVal[i] : ~errIn[i];
      end
  end
endmodule : cmp_sense_model

//--- test/tb_top.sv
// self-checking bench for the multiphase modulator
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; $display("ERROR %0t got %0d exp %0d", $time, (g), (e)); end end
module tb_top;
  import cmp_pkg::*;
  localparam int NS = 6;
  localparam int P0 = 130;
  localparam int P1 = 200;
  localparam int SPR = P0 * 3 / 13;
  logic mclk, arst_n, ce, enable, restart, syncIn, syncOut;
  logic [CMP_NRAIL-1:0][CMP_PERW-1:0] period, sampleAt;
  logic [NS-1:0][CMP_RAILW-1:0] stageRail;
  logic [NS-1:0] stageOn, gate, gPrev;
  logic [CMP_NRAIL-1:0] railRamp, railLight, errDone, syncInMask, convTrig, senseEn;
  cmp_coef_type [CMP_NRAIL-1:0][CMP_NBANK-1:0] coef;
  logic [CMP_NRAIL-1:0][CMP_ERRCW-1:0] errIn, errVal;
  logic [7:0] syncOutSel;
  logic [CMP_NRAIL-1:0][CMP_DUTYW:0] dutyOut;
  logic [CMP_NRAIL-1:0][1:0] bankOut;
  logic live, enPrev;
  int fail_count, n_compared, cyc, cycE0, y1, pend, bk, bkV, wid, appl;
  int lim[4] = '{-20, -5, 3, 15};
  int lp[4] = '{1, 4, 9, 20};
  // gains kept small: a late stage could otherwise rise early at a threshold step
  int gn[5] = '{-18, 4, 8, 12, 18};
  int ph[NS] = '{0, P0 / 3, 2 * P0 / 3, SPR, 0, 0};
  int pr[NS] = '{P0, P0, P0, P1, 1, 1};
  int tph[4] = '{20, 0, 0, SPR + 20};
  int tpr[4] = '{P0, 1, 1, P1};
  cmp_multiphase_pwm #(.NSTAGE(NS), .ERRCW(CMP_ERRCW)) DUT (.mclk(mclk), .arst_n(arst_n), .ce(ce),
    .enable(enable), .restart(restart), .period(period), .sampleAt(sampleAt), .stageRail(stageRail),
    .stageOn(stageOn), .railRamp(railRamp), .railLight(railLight), .coef(coef), .errIn(errIn),
    .errDone(errDone), .syncInMask(syncInMask), .syncOutSel(syncOutSel), .syncIn(syncIn), .gate(gate),
    .convTrig(convTrig), .senseEn(senseEn), .syncOut(syncOut), .dutyOut(dutyOut), .bankOut(bankOut));
  cmp_sense_model u_sense (.mclk(mclk), .arst_n(arst_n), .convTrig(convTrig), .errVal(errVal),
    .errIn(errIn), .errDone(errDone));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic int duty_of(int raw, int b);
    int e, s, y;
    e = raw > 31 ? 31 : (raw < -32 ? -32 : raw);
    s = 0;
    for (int l = 0; l < 4; l++) if (e > (b == 2 ? lp[l] : lim[l])) s++;
    y = e * (gn[s] + b) + (y1 >>> 1);
    y1 = y;
    return y < 0 ? 0 : (y > 4096 ? 4096 : y);
  endfunction : duty_of
  function automatic bit ok(int m, int p, int q);
    return (((m - 2 - p) % q) + q) % q == 0;
  endfunction : ok
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic run(input int n);
    repeat (n)
    begin
      @(posedge mclk);
      for (int r = 0; r < CMP_NRAIL; r++)
        errVal[r] <= ($urandom % 4 == 0) ? CMP_ERRCW'($urandom) : CMP_ERRCW'($urandom_range(63) - 32);
      railRamp <= CMP_NRAIL'($urandom);
      railLight <= CMP_NRAIL'($urandom);
    end
  endtask : run
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    if (!arst_n)
    begin
      enPrev = 1'b0;
      wid = 0;
    end
    else
    begin
      if ((enable && !enPrev) || (restart && enable && enPrev)) cycE0 = cyc;
      if (enable && !enPrev)
      begin
        y1 = 0;
        pend = 0;
        bkV = 0;
      end
      if (live && enable && cyc - cycE0 > 3)
      begin
        `CHK(senseEn, 4'h9)
        `CHK(gate[5:4], 2'h0)
        if (convTrig[0]) `CHK(dutyOut[0], pend)
        if (convTrig[0] && bkV) `CHK(bankOut[0], bk)
        for (int s = 0; s < NS; s++) if (gate[s] && !gPrev[s]) `CHK(ok(cyc - cycE0, ph[s], pr[s]), 1'b1)
        for (int i = 0; i < 4; i++) if (convTrig[i]) `CHK(ok(cyc - cycE0, tph[i], tpr[i]), 1'b1)
        if (!gate[0] && gPrev[0] && wid > 0) `CHK(wid, appl * P0 / 4096)
      end
      if (errDone[0] && enPrev)
      begin
        bk = railRamp[0] ? 0 : (railLight[0] ? 2 : 1);
        pend = duty_of(int'($signed(errIn[0])), bk);
        bkV = 1;
      end
      if (gate[0] && !gPrev[0])
      begin
        wid = 1;
        appl = pend;
      end
      else if (gate[0]) wid++;
      else wid = 0;
      enPrev = enable;
    end
    gPrev = gate;
    cyc++;
  end
  initial
  begin
    #(100 * 20000);
    fail_count++;
    $display("ERROR %0t watchdog expired", $time);
    wrap_up();
  end
  initial
  begin
    {arst_n, enable, restart, syncIn, live, railRamp, railLight, syncInMask} = '0;
    {errVal, cyc, cycE0, y1, pend, bk, bkV, wid, appl} = '0;
    ce = 1'b1;
    syncOutSel = 8'hff;
    period = {16'd300, 16'd300, 16'd200, 16'd130};
    sampleAt = {4{16'd20}};
    stageRail = 12'h040;
    stageOn = 6'h0f;
    for (int r = 0; r < CMP_NRAIL; r++)
      for (int b = 0; b < CMP_NBANK; b++)
      begin
        coef[r][b] = '0;
        for (int l = 0; l < 4; l++) coef[r][b].limit[l] = CMP_ERRW'(b == 2 ? lp[l] : lim[l]);
        for (int g = 0; g < 5; g++) coef[r][b].gain[g] = CMP_GAINW'(gn[g] + b);
        coef[r][b].bq[0] = 16'h4000;
        coef[r][b].fo[0] = 16'h4000;
        coef[r][b].fo[2] = 16'he000;
      end
    void'($urandom(45547));
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    enable <= 1'b1;
    live <= 1'b1;
    run(20 * P0);
    // sync breaks spacing, so the model checks pause until 2*P1 cycles after restart
    live <= 1'b0;
    syncInMask <= 4'h1;
    syncOutSel <= 8'h00;
    repeat (3)
    begin
      run(57);
      syncIn <= 1'b1;
      run(5);
      syncIn <= 1'b0;
    end
    run(1);
    restart <= 1'b1;
    run(1);
    restart <= 1'b0;
    syncInMask <= 4'h0;
    run(2 * P1);
    live <= 1'b1;
    run(8 * P0);
    arst_n <= 1'b0;
    enable <= 1'b0;
    run(3);
    arst_n <= 1'b1;
    run(2);
    enable <= 1'b1;
    run(6 * P0);
    wrap_up();
  end
endmodule : tb_top
